/* twbt_pkg.sv */
package twbt_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_SLAVE    = 8'h04;
	localparam logic [7:0] REG_PAT_VAL  = 8'h08;
	localparam logic [7:0] REG_PAT_CARE = 8'h0C;
	localparam logic [7:0] REG_OFFSET   = 8'h10;
	localparam logic [7:0] REG_STATUS   = 8'h14;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [8:0]  CTRL_RST   = 9'h000;
	localparam logic [9:0]  SLAVE_RST  = 10'h000;
	localparam logic [23:0] PAT_RST    = 24'h000000;
	localparam logic [23:0] CARE_RST   = 24'h000000;
	localparam logic [11:0] OFFSET_RST = 12'h000;

	////////////////////////////////////////////////////////////////////////
	// Bus framing constants
	localparam logic [3:0]  DIR_BIT    = 4'h7;
	localparam logic [3:0]  ACK_BIT    = 4'h8;
	localparam logic [4:0]  TEN_PREFIX = 5'h1E;
	localparam logic [12:0] IDX_MAX    = 13'h1FFF;

	typedef enum logic [2:0] {
		SEL_START   = 3'b000,
		SEL_STOP    = 3'b001,
		SEL_RESTART = 3'b010,
		SEL_NACK    = 3'b011,
		SEL_RW      = 3'b100,
		SEL_DATA    = 3'b101
	} twbt_sel_t;

	// Control register layout, bit 0 upward: sel, dir, ten_bit, addr_rw,
	// pattern_byte_count, hex
	typedef struct packed {
		logic       hex;
		logic [1:0] pattern_byte_count;
		logic       addr_rw;
		logic       ten_bit;
		logic       dir;
		twbt_sel_t  sel;
	} twbt_cfg_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ADDR  = 2'b01,
		ST_ADDR2 = 2'b10,
		ST_DATA  = 2'b11
	} twbt_state_t;

endpackage

/* twbt_top.sv */
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps

// Contract
// - Detect start as SDA falling while SCL high; trigger when start selected.
// - Detect stop as SDA rising while SCL high; trigger when stop selected.
// - Restart selected: trigger on a start seen inside an open frame.
// - Ninth bit of each unit is the ack slot; high there is a not-acknowledge.
// - Not-acknowledge selected: trigger on any acknowledge slot sampled high.
// - Direction is the eighth bit of the first unit after start.
// - Direction 1 means master reads, 0 means master writes.
// - Address is reported as seven bits, or ten in ten-bit mode, direction flagged separately.
// - Configuration compares address with or without the direction bit.
// - Ten-bit addressing through the reserved prefix, up to 0x3FF.
// - Read/write trigger needs matching direction and matching slave address.
// - Data match compares one to three bytes, count set by configuration.
// - A byte offset of 0 to 4095 precedes the first compared byte.
// - Each pattern bit is one, zero or don't-care.
// - In hex mode don't-care applies to whole bytes only.
module twbt_top (
	// Clock and reset
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RSTN_IN,
	// Wishbone slave
	input  wire logic        WB_CYC_IN,
	input  wire logic        WB_STB_IN,
	input  wire logic        WB_WE_IN,
	input  wire logic [7:0]  WB_ADR_IN,
	input  wire logic [3:0]  WB_SEL_IN,
	input  wire logic [31:0] WB_DAT_IN,
	output logic      [31:0] WB_DAT_OUT,
	output logic             WB_ACK_OUT,
	// Monitored bus
	input  wire logic        SCL_IN,
	input  wire logic        SDA_IN,
	// Trigger
	output logic             TRIG_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Register file over Wishbone

	twbt_pkg::twbt_cfg_t cfg, next_cfg;
	logic [9:0]          slave, next_slave;
	logic [23:0]         pat, next_pat;
	logic [23:0]         care, next_care;
	logic [11:0]         offset, next_offset;
	logic                wb_ack, next_wb_ack;
	logic [31:0]         rdat, next_rdat;
	logic [31:0]         status;
	logic                req;
	twbt_pkg::twbt_state_t state, next_state;
	logic                  in_frame, next_in_frame;
	logic                  dir, next_dir;
	logic                  nack, next_nack;
	logic                  addr_ok, next_addr_ok;
	logic [9:0]            last_addr, next_last_addr;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] lanes);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (lanes[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	assign req    = WB_CYC_IN & WB_STB_IN & ~wb_ack;
	assign status = {6'h00, last_addr, 10'h000, state,
		addr_ok, nack, dir, in_frame};

	always_comb begin
		next_cfg    = cfg;
		next_slave  = slave;
		next_pat    = pat;
		next_care   = care;
		next_offset = offset;
		next_wb_ack = req;
		next_rdat   = rdat;
		if (req) begin
			// Unmapped offsets read zero and ignore writes
			unique case (WB_ADR_IN)
				twbt_pkg::REG_CTRL:     next_rdat = {23'h000000, cfg};
				twbt_pkg::REG_SLAVE:    next_rdat = {22'h000000, slave};
				twbt_pkg::REG_PAT_VAL:  next_rdat = {8'h00, pat};
				twbt_pkg::REG_PAT_CARE: next_rdat = {8'h00, care};
				twbt_pkg::REG_OFFSET:   next_rdat = {20'h00000, offset};
				twbt_pkg::REG_STATUS:   next_rdat = status;
				default:                next_rdat = 32'h00000000;
			endcase
			if (WB_WE_IN) begin
				unique case (WB_ADR_IN)
					twbt_pkg::REG_CTRL: next_cfg = twbt_pkg::twbt_cfg_t'(9'(
						merge({23'h000000, cfg}, WB_DAT_IN, WB_SEL_IN)));
					twbt_pkg::REG_SLAVE: next_slave = 10'(merge(
						{22'h000000, slave}, WB_DAT_IN, WB_SEL_IN));
					twbt_pkg::REG_PAT_VAL: next_pat =
						24'(merge({8'h00, pat}, WB_DAT_IN, WB_SEL_IN));
					twbt_pkg::REG_PAT_CARE: next_care =
						24'(merge({8'h00, care}, WB_DAT_IN, WB_SEL_IN));
					twbt_pkg::REG_OFFSET: next_offset = 12'(merge(
						{20'h00000, offset}, WB_DAT_IN, WB_SEL_IN));
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			cfg    <= twbt_pkg::twbt_cfg_t'(twbt_pkg::CTRL_RST);
			slave  <= twbt_pkg::SLAVE_RST;
			pat    <= twbt_pkg::PAT_RST;
			care   <= twbt_pkg::CARE_RST;
			offset <= twbt_pkg::OFFSET_RST;
			wb_ack <= 1'b0;
			rdat   <= 32'h00000000;
		end else begin
			cfg    <= next_cfg;
			slave  <= next_slave;
			pat    <= next_pat;
			care   <= next_care;
			offset <= next_offset;
			wb_ack <= next_wb_ack;
			rdat   <= next_rdat;
		end
	end

	assign WB_ACK_OUT = wb_ack;
	assign WB_DAT_OUT = rdat;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; edges come from the second stage onward only

	logic scl_meta, scl_s, scl_prev;
	logic sda_meta, sda_s, sda_prev;
	logic start_ev, stop_ev, scl_rise;
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			scl_meta <= 1'b1;
			scl_s    <= 1'b1;
			scl_prev <= 1'b1;
			sda_meta <= 1'b1;
			sda_s    <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_meta <= SCL_IN;
			scl_s    <= scl_meta;
			scl_prev <= scl_s;
			sda_meta <= SDA_IN;
			sda_s    <= sda_meta;
			sda_prev <= sda_s;
		end
	end

	// SCL must stay high across the SDA edge, so both samples are checked
	assign start_ev = scl_s & scl_prev & sda_prev & ~sda_s;
	assign stop_ev  = scl_s & scl_prev & ~sda_prev & sda_s;
	assign scl_rise = scl_s & ~scl_prev;

	////////////////////////////////////////////////////////////////////////
	// Frame decoder and trigger

	logic [3:0]  bit_cnt, next_bit_cnt;
	logic [7:0]  sreg, next_sreg;
	logic [1:0]  addr_hi, next_addr_hi;
	logic        data_ok, next_data_ok;
	logic [12:0] data_idx, next_data_idx;
	logic        trig, next_trig;
	logic [7:0]  byte_val, pat_b, care_b, care_e;
	logic [12:0] rel, ncmp;
	logic        ok7, ok10, in_win, hit;
	always_comb begin
		next_state     = state;
		next_in_frame  = in_frame;
		next_dir       = dir;
		next_nack      = nack;
		next_addr_ok   = addr_ok;
		next_last_addr = last_addr;
		next_bit_cnt   = bit_cnt;
		next_sreg      = sreg;
		next_addr_hi   = addr_hi;
		next_data_ok   = data_ok;
		next_data_idx  = data_idx;
		next_trig      = 1'b0;
		byte_val       = {sreg[6:0], sda_s};
		ok7 = cfg.addr_rw ? (byte_val == slave[7:0])
			: (byte_val[7:1] == slave[6:0]);
		ok10 = ({addr_hi, byte_val} == slave);
		ncmp = (cfg.pattern_byte_count == 2'b00) ? 13'h0001
			: {11'h000, cfg.pattern_byte_count};
		rel    = data_idx - {1'b0, offset};
		in_win = (data_idx >= {1'b0, offset}) && (rel < ncmp);
		unique case (rel[1:0])
			2'b00:   begin pat_b = pat[7:0];   care_b = care[7:0];   end
			2'b01:   begin pat_b = pat[15:8];  care_b = care[15:8];  end
			default: begin pat_b = pat[23:16]; care_b = care[23:16]; end
		endcase
		// Hex entry can only blank a byte as a whole
		care_e = cfg.hex ? {8{|care_b}} : care_b;
		hit    = ((byte_val ^ pat_b) & care_e) == 8'h00;
		if (start_ev) begin
			next_trig = (cfg.sel == twbt_pkg::SEL_START)
				| ((cfg.sel == twbt_pkg::SEL_RESTART) & in_frame);
			next_in_frame = 1'b1;
			next_state    = twbt_pkg::ST_ADDR;
			next_bit_cnt  = 4'h0;
			next_addr_ok  = 1'b0;
			next_data_ok  = 1'b1;
			next_data_idx = 13'h0000;
		end else if (stop_ev) begin
			next_trig     = (cfg.sel == twbt_pkg::SEL_STOP);
			next_in_frame = 1'b0;
			next_state    = twbt_pkg::ST_IDLE;
			next_bit_cnt  = 4'h0;
		end else if (scl_rise && state != twbt_pkg::ST_IDLE) begin
			next_sreg = byte_val;
			if (bit_cnt == twbt_pkg::ACK_BIT) begin
				next_bit_cnt = 4'h0;
				next_nack    = sda_s;
				next_trig    = (cfg.sel == twbt_pkg::SEL_NACK) & sda_s;
			end else begin
				next_bit_cnt = bit_cnt + 4'h1;
			end
			if (bit_cnt == twbt_pkg::DIR_BIT) begin
				unique case (state)
					twbt_pkg::ST_ADDR: begin
						next_dir = sda_s;
						if (cfg.ten_bit &&
							byte_val[7:3] == twbt_pkg::TEN_PREFIX) begin
							next_addr_hi = byte_val[2:1];
							next_state   = twbt_pkg::ST_ADDR2;
						end else begin
							next_addr_ok   = ok7;
							next_last_addr = {3'h0, byte_val[7:1]};
							next_state     = twbt_pkg::ST_DATA;
							next_trig = (cfg.sel == twbt_pkg::SEL_RW)
								& ok7 & (sda_s == cfg.dir);
						end
					end
					twbt_pkg::ST_ADDR2: begin
						next_addr_ok   = ok10;
						next_last_addr = {addr_hi, byte_val};
						next_state     = twbt_pkg::ST_DATA;
						next_trig = (cfg.sel == twbt_pkg::SEL_RW)
							& ok10 & (dir == cfg.dir);
					end
					twbt_pkg::ST_DATA: begin
						if (in_win) begin
							next_data_ok = data_ok & hit;
							next_trig = (cfg.sel == twbt_pkg::SEL_DATA)
								& (rel == ncmp - 13'h0001)
								& data_ok & hit & addr_ok;
						end
						if (data_idx != twbt_pkg::IDX_MAX) begin
							next_data_idx = data_idx + 13'h0001;
						end
					end
					twbt_pkg::ST_IDLE: ;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state     <= twbt_pkg::ST_IDLE;
			in_frame  <= 1'b0;
			dir       <= 1'b0;
			nack      <= 1'b0;
			addr_ok   <= 1'b0;
			last_addr <= 10'h000;
			bit_cnt   <= 4'h0;
			sreg      <= 8'h00;
			addr_hi   <= 2'h0;
			data_ok   <= 1'b0;
			data_idx  <= 13'h0000;
			trig      <= 1'b0;
		end else begin
			state     <= next_state;
			in_frame  <= next_in_frame;
			dir       <= next_dir;
			nack      <= next_nack;
			addr_ok   <= next_addr_ok;
			last_addr <= next_last_addr;
			bit_cnt   <= next_bit_cnt;
			sreg      <= next_sreg;
			addr_hi   <= next_addr_hi;
			data_ok   <= next_data_ok;
			data_idx  <= next_data_idx;
			trig      <= next_trig;
		end
	end

	assign TRIG_OUT = trig;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RSTN_IN);
	start_opens_frame_a: assert property (
		start_ev |=> in_frame && state == twbt_pkg::ST_ADDR && bit_cnt == 0)
		else $error("start did not open a frame");
	start_trigger_a: assert property (
		start_ev && cfg.sel == twbt_pkg::SEL_START |=> TRIG_OUT)
		else $error("start trigger missing");
	stop_trigger_a: assert property (
		stop_ev && cfg.sel == twbt_pkg::SEL_STOP |=> TRIG_OUT && !in_frame)
		else $error("stop trigger missing");
	restart_trigger_a: assert property (
		start_ev && cfg.sel == twbt_pkg::SEL_RESTART
		|=> TRIG_OUT == $past(in_frame))
		else $error("restart trigger wrong");
	nack_trigger_a: assert property (
		scl_rise && state != twbt_pkg::ST_IDLE && !start_ev && !stop_ev
		&& bit_cnt == twbt_pkg::ACK_BIT && cfg.sel == twbt_pkg::SEL_NACK
		|=> TRIG_OUT == $past(sda_s) && nack == $past(sda_s))
		else $error("nack slot misjudged");
	dir_capture_a: assert property (
		scl_rise && state == twbt_pkg::ST_ADDR && !start_ev && !stop_ev
		&& bit_cnt == twbt_pkg::DIR_BIT |=> dir == $past(sda_s))
		else $error("direction not taken from eighth bit");
	trig_pulse_a: assert property (TRIG_OUT |=> !TRIG_OUT)
		else $error("trigger longer than one cycle");
	stop_idles_a: assert property (
		stop_ev |=> state == twbt_pkg::ST_IDLE ##1 !TRIG_OUT)
		else $error("stop did not idle match state");
	wb_ack_once_a: assert property (
		WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
		else $error("bus answer timing wrong");

endmodule // twbt_top

/* twbt_bus_model.sv */
`timescale 1ns/1ps
module twbt_bus_model (
	// Sampling clock
	input  wire logic clk_in,
	// Monitored lines, pulled high when released
	output logic      scl_out,
	output logic      sda_out
);

	// Lines rest high: clock stands still between frames
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Half of the 80 ns link period
	task automatic hp;
		repeat (4) @(posedge clk_in);
	endtask

	// Data changes a cycle after the clock falls, so it never moves with it
	task automatic send_bit(input logic b);
		sda_out <= b;
		repeat (3) @(posedge clk_in);
		scl_out <= 1'b1;
		hp;
		scl_out <= 1'b0;
		@(posedge clk_in);
	endtask

	// Data released first, so a repeated start never looks like a stop
	task automatic start;
		sda_out <= 1'b1;
		hp;
		scl_out <= 1'b1;
		hp;
		sda_out <= 1'b0;
		hp;
		scl_out <= 1'b0;
		hp;
	endtask

	task automatic stop;
		sda_out <= 1'b0;
		hp;
		scl_out <= 1'b1;
		hp;
		sda_out <= 1'b1;
		hp;
	endtask

	task automatic send_byte(input logic [7:0] v, input logic nack);
		for (int i = 7; i >= 0; i--) send_bit(v[i]);
		send_bit(nack);
	endtask

endmodule // twbt_bus_model

/* twbt_tb_top.sv */
`timescale 1ns/1ps
module twbt_tb_top;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic [31:0] q;
	logic        ack;
	logic        scl;
	logic        sda;
	logic        trig;
	int          errors = 0;
	int          n_tests = 0;
	int          ntrig = 0;

	always #5 clk = ~clk;

	twbt_top DUT (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .WB_CYC_IN(cyc),
		.WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
		.WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack),
		.SCL_IN(scl), .SDA_IN(sda), .TRIG_OUT(trig));

	twbt_bus_model M (.clk_in(clk), .scl_out(scl), .sda_out(sda));

	// A pulse wider than one cycle shows as an extra count
	always @(posedge clk) if (trig === 1'b1) ntrig++;

	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_trig(input int e);
		chk_reg(ntrig, e);
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk_reg(q, e);
	endtask

	task automatic cfg(input logic [8:0] c);
		wb(1'b1, twbt_pkg::REG_CTRL, {23'h0, c});
	endtask

	// Data goes out high byte first; a reading master nacks the last
	task automatic frm(input logic [7:0] a, input logic [23:0] d,
		input int n, input int e);
		ntrig = 0;
		M.start();
		M.send_byte(a, 1'b0);
		for (int i = n - 1; i >= 0; i--) begin
			M.send_byte(d[8*i+:8], a[0] && i == 0);
		end
		M.stop();
		repeat (8) @(posedge clk);
		chk_trig(e);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		errors++;
		tally_and_finish;
	end

	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(twbt_pkg::REG_CTRL, 32'h0);
		rd(twbt_pkg::REG_OFFSET, 32'h0);
		rd(8'h20, 32'h0);
		wb(1'b1, twbt_pkg::REG_OFFSET, 32'hFFFFFFFF);
		rd(twbt_pkg::REG_OFFSET, 32'h00000FFF);
		$display("Test registers done");
		cfg(9'h000);
		frm(8'hA0, 24'h11, 1, 1);
		cfg(9'h001);
		frm(8'hA0, 24'h11, 1, 1);
		cfg(9'h002);
		frm(8'hA0, 24'h11, 1, 0);
		ntrig = 0;
		M.start();
		M.send_byte(8'hA0, 1'b0);
		M.start();
		M.send_byte(8'hA1, 1'b0);
		M.send_byte(8'h55, 1'b1);
		M.stop();
		repeat (8) @(posedge clk);
		chk_trig(1);
		cfg(9'h003);
		frm(8'hA0, 24'h1122, 2, 0);
		frm(8'hA1, 24'h1122, 2, 1);
		$display("Test events done");
		wb(1'b1, twbt_pkg::REG_SLAVE, 32'h50);
		cfg(9'h00C);
		frm(8'hA1, 24'h33, 1, 1);
		frm(8'hA0, 24'h33, 1, 0);
		frm(8'hA3, 24'h33, 1, 0);
		cfg(9'h004);
		frm(8'hA0, 24'h33, 1, 1);
		wb(1'b1, twbt_pkg::REG_SLAVE, 32'hA1);
		cfg(9'h02C);
		frm(8'hA1, 24'h33, 1, 1);
		cfg(9'h00C);
		frm(8'hA1, 24'h33, 1, 0);
		wb(1'b1, twbt_pkg::REG_SLAVE, 32'h3FF);
		cfg(9'h014);
		frm(8'hF6, 24'hFF, 1, 1);
		frm(8'hF6, 24'hFE, 1, 0);
		$display("Test address done");
		wb(1'b1, twbt_pkg::REG_SLAVE, 32'h50);
		wb(1'b1, twbt_pkg::REG_OFFSET, 32'h1);
		wb(1'b1, twbt_pkg::REG_PAT_VAL, 32'h3412);
		wb(1'b1, twbt_pkg::REG_PAT_CARE, 32'hFFFF);
		cfg(9'h085);
		frm(8'hA0, 24'h991234, 3, 1);
		frm(8'hA0, 24'h991235, 3, 0);
		frm(8'hA0, 24'h1234, 2, 0);
		wb(1'b1, twbt_pkg::REG_PAT_CARE, 32'hFF0F);
		frm(8'hA0, 24'h99F234, 3, 1);
		cfg(9'h185);
		frm(8'hA0, 24'h99F234, 3, 0);
		wb(1'b1, twbt_pkg::REG_PAT_CARE, 32'hFF00);
		frm(8'hA0, 24'h99F234, 3, 1);
		wb(1'b1, twbt_pkg::REG_OFFSET, 32'h0);
		wb(1'b1, twbt_pkg::REG_PAT_VAL, 32'h563412);
		wb(1'b1, twbt_pkg::REG_PAT_CARE, 32'hFFFFFF);
		cfg(9'h0C5);
		frm(8'hA0, 24'h123456, 3, 1);
		frm(8'hA0, 24'h123457, 3, 0);
		cfg(9'h005);
		frm(8'hA0, 24'h12, 1, 1);
		rd(twbt_pkg::REG_STATUS, 32'h00500008);
		$display("Test data done");
		tally_and_finish;
	end

endmodule // twbt_tb_top
